/* inc/scm_pkg.sv */
// Package: register map, field layout and reset values of the serial control block
package scm_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CONTROL  = 4'h0;   // Serial control, low half
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h4;   // Sticky event bits, write one to clear
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h8;   // Event enables, same layout
  localparam logic [3:0] ADDR_STATE    = 4'hC;   // Live block state, read only

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int CTL_FILTER_BIT  = 3;            // Multidrop receive filter
  localparam int CTL_TX_END_IRQ_EN_BIT    = 2;            // Transmit-end irq enable
  localparam int CTL_SEL_HI_BIT  = 1;            // Clock source select, high
  localparam int CTL_SEL_LO_BIT  = 0;            // Clock source select, low
  localparam logic [7:0] CTL_RESET = 8'h00;      // All fields zero

  // ----------------------------------------------------------------
  // Event bits (status and mask share this layout)
  // ----------------------------------------------------------------
  localparam int EVT_DISCARD  = 0;               // Character dropped by filter
  localparam int EVT_RELEASE  = 1;               // Filter released by address char
  localparam int EVT_TX_END   = 2;               // Transmit-end flag rose
  localparam int EVT_WIDTH    = 3;
  localparam logic [2:0] EVT_RESET  = 3'h0;
  localparam logic [2:0] MASK_RESET = 3'h0;

  // ----------------------------------------------------------------
  // State register fields
  // ----------------------------------------------------------------
  localparam int ST_FILTER_ACT = 0;              // Filter currently effective
  localparam int ST_EXT_CLK    = 1;              // Clock taken from the pin
  localparam int ST_PIN_DRIVEN = 2;              // Pin driven by the block
  localparam int ST_PIN_LEVEL  = 3;              // Synchronised pin level

  // ----------------------------------------------------------------
  // Clock select encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] SEL_INT_QUIET = 2'h0;   // Internal, pin unused (async)
  localparam logic [1:0] SEL_INT_OUT   = 2'h1;   // Internal, pin drives clock

  // Internal 16x ticks per bit-rate clock period
  localparam int          OVERSAMPLE  = 16;
  localparam logic [3:0]  DIV_RESET   = 4'h0;

endpackage

/* design/scm_edge_sync.sv */
// Two-flop pin synchroniser with rise detection on the settled level
`timescale 1ns/1ps
`default_nettype none

module scm_edge_sync (
  input  wire logic i_sys_clk,      // System clock
  input  wire logic i_sys_rst,      // Synchronous reset, high
  input  wire logic i_clk_en,       // Freezes all state when low
  input  wire logic i_pin,          // Asynchronous pin level
  output logic      o_level,        // Settled level
  output logic      o_rise          // One-cycle pulse on rising edge
);

  // ----------------------------------------------------------------
  // Synchroniser chain
  // ----------------------------------------------------------------
  logic meta_q;                     // First stage, read only by second
  logic sync_q;                     // Second stage, safe to use
  logic last_q;                     // Previous settled level

  // Only the second stage looks at the first; avoids metastable fan-out
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      // Start at the pin's idle high level, so no false rise follows reset
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      last_q <= 1'b1;
    end else if (i_clk_en) begin
      meta_q <= i_pin;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_level = sync_q;
  assign o_rise  = sync_q & ~last_q;

endmodule
`default_nettype wire

/* design/scm_serial_ctrl.sv */
// Serial control low half: multidrop filter, transmit-end irq gate, clock source selection
`timescale 1ns/1ps
`default_nettype none

module scm_serial_ctrl (
  input  wire logic        i_sys_clk,          // 200 MHz system clock
  input  wire logic        i_sys_rst,          // Synchronous reset, high
  input  wire logic        i_clk_en,           // Freezes all state when low
  // Avalon-MM slave
  input  wire logic [3:0]  i_avs_address,      // Byte address
  input  wire logic        i_avs_read,         // Read request
  input  wire logic        i_avs_write,        // Write request
  input  wire logic [31:0] i_avs_writedata,    // Write data
  input  wire logic [3:0]  i_avs_byteenable,   // Byte lanes
  output logic [31:0]      o_avs_readdata,     // Read data
  output logic             o_avs_waitrequest,  // Slave not ready
  // Format and mode from the rest of the port
  input  wire logic        i_async_mode,       // 1 = asynchronous, 0 = clocked sync
  input  wire logic        i_multidrop_mode,   // Multidrop format selected
  input  wire logic        i_parity_en,        // Parity enable setting
  input  wire logic        i_parity_odd,       // Parity mode setting
  // Receiver character events
  input  wire logic        i_rx_char_done,     // Pulse: character received
  input  wire logic        i_rx_mp_bit,        // Multidrop bit of that character
  input  wire logic        i_rx_frame_err,     // Stop bit was 0
  input  wire logic        i_rx_full_flag,     // Receive data still unread
  output logic             o_rx_deliver,       // Pulse: move character to data reg
  output logic             o_rx_full_set,      // Pulse: set receive-full flag
  output logic             o_frame_err_set,    // Pulse: set framing error flag
  output logic             o_overrun_set,      // Pulse: set overrun flag
  output logic             o_parity_active,    // Parity add/check in effect
  output logic             o_parity_odd,       // Odd parity in effect
  // Transmit end
  input  wire logic        i_tx_end_flag,      // Transmit-end status flag
  output logic             o_tx_end_irq,       // Transmit-end request
  // Clock source
  input  wire logic        i_baud_tick,        // Baud generator tick (16x async, 2x sync)
  output logic             o_clk_tick,         // Pulse: selected clock tick
  output logic             o_ext_clk,          // Clock taken from pin
  // Serial clock pin
  input  wire logic        i_sck,              // Pin level in
  output logic             o_sck,              // Pin level out
  output logic             o_sck_oe_n,         // Low while the block drives the pin
  // Interrupt
  output logic             o_irq               // High while an unmasked event is set
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0]  ctl_q;                          // Control register
  logic [2:0]  evt_q;                          // Sticky events
  logic [2:0]  evt_d;                          // Next sticky events
  logic [2:0]  mask_q;                         // Event mask
  logic [2:0]  evt_new;                        // Events raised this cycle
  logic        wait_q;                         // Waitrequest register
  logic [31:0] rdata_q;                        // Read data register
  logic [31:0] rdata_d;                        // Decoded read value
  logic        req;                            // Read or write pending
  logic        wr_take;                        // Write accepted this edge
  logic        wr_ctl;                         // Control write accepted
  logic        filter_act;                     // Filter effective now
  logic        ext_sel;                        // Pin is the clock source
  logic        drive_pin;                      // Block drives the pin
  logic        sck_level;                      // Synchronised pin level
  logic        sck_rise;                       // Pin rising edge
  logic [3:0]  div_q;                          // Internal clock divider
  logic        sync_clk_q;                     // Internal shift clock level
  logic        tx_end_last_q;                  // Previous transmit-end flag
  logic        rx_drop;                        // Character to discard
  logic        rx_wake;                        // Address character seen

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  scm_edge_sync u_sck_sync (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .i_clk_en  (i_clk_en),
    .i_pin     (i_sck),
    .o_level   (sck_level),
    .o_rise    (sck_rise)
  );

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  assign req     = i_avs_read | i_avs_write;
  // Write lands only at the edge where the master sees waitrequest low
  assign wr_take = i_avs_write & ~wait_q;
  assign wr_ctl  = wr_take & i_avs_byteenable[0] & (i_avs_address == scm_pkg::ADDR_CONTROL);

  // Read mux; unmapped addresses return zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    case (i_avs_address)
      scm_pkg::ADDR_CONTROL:  rdata_d[7:0] = ctl_q;
      scm_pkg::ADDR_IRQ_STAT: rdata_d[2:0] = evt_q;
      scm_pkg::ADDR_IRQ_MASK: rdata_d[2:0] = mask_q;
      scm_pkg::ADDR_STATE: begin
        rdata_d[scm_pkg::ST_FILTER_ACT] = filter_act;
        rdata_d[scm_pkg::ST_EXT_CLK]    = ext_sel;
        rdata_d[scm_pkg::ST_PIN_DRIVEN] = drive_pin;
        rdata_d[scm_pkg::ST_PIN_LEVEL]  = sck_level;
      end
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  // One wait cycle per request, then a single ready cycle with data
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else if (i_clk_en) begin
      if (req && wait_q) begin
        wait_q  <= 1'b0;
        rdata_q <= rdata_d;
      end else begin
        wait_q  <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  // Upper bits belong to the other half of the port and read as zero here
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      ctl_q <= scm_pkg::CTL_RESET;
    end else if (i_clk_en) begin
      if (wr_ctl) begin
        // Software write wins over the hardware clear in the same cycle
        ctl_q <= {4'h0, i_avs_writedata[3:0]};
      end else if (rx_wake) begin
        ctl_q[scm_pkg::CTL_FILTER_BIT] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Multidrop receive filter
  // ----------------------------------------------------------------
  // Bit only counts in async multidrop format
  assign filter_act = ctl_q[scm_pkg::CTL_FILTER_BIT] & i_multidrop_mode & i_async_mode;
  assign rx_drop    = i_rx_char_done & filter_act & ~i_rx_mp_bit;
  assign rx_wake    = i_rx_char_done & filter_act & i_rx_mp_bit;

  // Flag-set pulses to the status register; none for dropped data
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_rx_deliver    <= 1'b0;
      o_rx_full_set   <= 1'b0;
      o_frame_err_set <= 1'b0;
      o_overrun_set   <= 1'b0;
    end else if (i_clk_en) begin
      if (i_rx_char_done && !rx_drop) begin
        // Overrun keeps the unread data; framing error still delivers
        o_rx_deliver    <= ~i_rx_full_flag;
        o_rx_full_set   <= ~i_rx_full_flag & ~i_rx_frame_err;
        o_frame_err_set <= i_rx_frame_err;
        o_overrun_set   <= i_rx_full_flag;
      end else begin
        // Discarded or idle: every flag pulse held off
        o_rx_deliver    <= 1'b0;
        o_rx_full_set   <= 1'b0;
        o_frame_err_set <= 1'b0;
        o_overrun_set   <= 1'b0;
      end
    end
  end

  // Parity ignored under the multidrop format
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_parity_active <= 1'b0;
      o_parity_odd    <= 1'b0;
    end else if (i_clk_en) begin
      o_parity_active <= i_parity_en & i_async_mode & ~i_multidrop_mode;
      o_parity_odd    <= i_parity_odd & ~i_multidrop_mode;
    end
  end

  // ----------------------------------------------------------------
  // Transmit-end request
  // ----------------------------------------------------------------
  // Registered gate of flag and enable; drops one cycle after either clears
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_tx_end_irq <= 1'b0;
    end else if (i_clk_en) begin
      o_tx_end_irq <= i_tx_end_flag & ctl_q[scm_pkg::CTL_TX_END_IRQ_EN_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Clock source selection
  // ----------------------------------------------------------------
  // High select bit alone picks the pin in both modes
  assign ext_sel   = ctl_q[scm_pkg::CTL_SEL_HI_BIT];
  // Async drives only for 01; sync drives for 00 and 01
  assign drive_pin = ~ext_sel &
                     (~i_async_mode | (ctl_q[1:0] == scm_pkg::SEL_INT_OUT));

  // Divider: sixteen 16x ticks make one bit-rate period
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      div_q <= scm_pkg::DIV_RESET;
    end else if (i_clk_en) begin
      if (i_baud_tick) begin
        div_q <= div_q + 4'h1;
      end
    end
  end

  // Sync shift clock toggles on each internal tick
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      sync_clk_q <= 1'b1;
    end else if (i_clk_en) begin
      if (i_baud_tick) begin
        sync_clk_q <= ~sync_clk_q;
      end
    end
  end

  // Tick to the shifter and pin drive, all registered
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_clk_tick <= 1'b0;
      o_ext_clk  <= 1'b0;
      o_sck      <= 1'b1;
      o_sck_oe_n <= 1'b1;
    end else if (i_clk_en) begin
      o_ext_clk  <= ext_sel;
      o_sck_oe_n <= ~drive_pin;
      if (ext_sel) begin
        // Pin rising edges: 16x ticks async, shift edges sync
        o_clk_tick <= sck_rise;
        o_sck      <= 1'b1;
      end else if (i_async_mode) begin
        // Pin level ignored; output only meaningful for 01
        o_clk_tick <= i_baud_tick;
        o_sck      <= div_q[3];
      end else begin
        // Shift on internal rising edge of the driven clock
        o_clk_tick <= i_baud_tick & ~sync_clk_q;
        o_sck      <= sync_clk_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt events
  // ----------------------------------------------------------------
  always_comb begin
    evt_new = 3'h0;
    evt_new[scm_pkg::EVT_DISCARD] = rx_drop;
    evt_new[scm_pkg::EVT_RELEASE] = rx_wake;
    evt_new[scm_pkg::EVT_TX_END]  = i_tx_end_flag & ~tx_end_last_q;
  end

  // Clear by one, but a new event in the same cycle survives
  always_comb begin
    evt_d = evt_q;
    if (wr_take && i_avs_byteenable[0] && (i_avs_address == scm_pkg::ADDR_IRQ_STAT)) begin
      evt_d = evt_q & ~i_avs_writedata[2:0];
    end
    evt_d = evt_d | evt_new;
  end

  // Sticky status, edge history and mask
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      evt_q         <= scm_pkg::EVT_RESET;
      mask_q        <= scm_pkg::MASK_RESET;
      tx_end_last_q <= 1'b0;
    end else if (i_clk_en) begin
      evt_q         <= evt_d;
      tx_end_last_q <= i_tx_end_flag;
      if (wr_take && i_avs_byteenable[0] && (i_avs_address == scm_pkg::ADDR_IRQ_MASK)) begin
        mask_q <= i_avs_writedata[2:0];
      end
    end
  end

  // Level interrupt registered from the next sticky state, in step with evt_q
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_irq <= 1'b0;
    end else if (i_clk_en) begin
      o_irq <= |(evt_d & mask_q);
    end
  end

  // ----------------------------------------------------------------
  // Bus outputs
  // ----------------------------------------------------------------
  assign o_avs_waitrequest = wait_q;
  assign o_avs_readdata    = rdata_q;

endmodule
`default_nettype wire

/* test/scm_serial_ctrl_monitor.sv */
// Port checker for the serial control block
`timescale 1ns/1ps
`default_nettype none
module scm_serial_ctrl_monitor (
  input wire logic        i_sys_clk,
  input wire logic        i_sys_rst,
  input wire logic [3:0]  i_avs_address,
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0]  i_avs_byteenable,
  input wire logic        o_avs_waitrequest,
  input wire logic        i_async_mode,
  input wire logic        i_multidrop_mode,
  input wire logic        i_rx_char_done,
  input wire logic        i_rx_mp_bit,
  input wire logic        i_rx_frame_err,
  input wire logic        i_rx_full_flag,
  input wire logic        o_rx_deliver,
  input wire logic        o_rx_full_set,
  input wire logic        o_frame_err_set,
  input wire logic        o_overrun_set,
  input wire logic        o_parity_active,
  input wire logic        i_tx_end_flag,
  input wire logic        o_tx_end_irq,
  input wire logic        o_ext_clk,
  input wire logic        o_sck_oe_n
);
  // ----
  // Shadow of the control bits, rebuilt from bus writes
  // ----
  logic [3:0] ctl_q;  // Filter, irq enable, clock select
  wire acc = !o_avs_waitrequest && i_avs_write && i_avs_byteenable[0]
             && i_avs_address == scm_pkg::ADDR_CONTROL;
  wire eff = ctl_q[3] && i_multidrop_mode && i_async_mode;  // Filter in force
  wire drop = i_rx_char_done && !i_rx_mp_bit && eff;         // Char to discard
  // Write wins over the hardware clear of the filter bit
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      ctl_q <= 4'h0;
    end else if (acc) begin
      ctl_q <= i_avs_writedata[3:0];
    end else if (i_rx_char_done && i_rx_mp_bit && eff) begin
      ctl_q[3] <= 1'b0;
    end
  end
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  // ----
  // Assertions
  // ----
  AST_DISCARD: assert property (
    drop |=> !(o_rx_deliver || o_rx_full_set || o_frame_err_set || o_overrun_set))
    else $error("discarded char raised a flag");
  AST_DELIVER: assert property (i_rx_char_done && !drop && !i_rx_full_flag && !i_rx_frame_err
                                |=> o_rx_deliver && o_rx_full_set)
    else $error("char not delivered");
  AST_TXIRQ: assert property (o_tx_end_irq == $past(i_tx_end_flag && ctl_q[2]))
    else $error("tx end request mismatch");
  AST_QUIET_PIN: assert property ((i_async_mode && ctl_q[1:0] == 2'h0) [*3] |-> o_sck_oe_n)
    else $error("pin driven in quiet mode");
  AST_OUT_PIN: assert property ((!ctl_q[1] && (ctl_q[0] || !i_async_mode)) [*3] |-> !o_sck_oe_n)
    else $error("clock pin not driven");
  AST_EXT_PIN: assert property (ctl_q[1] [*3] |-> o_sck_oe_n && o_ext_clk)
    else $error("external clock not selected");
  AST_PARITY: assert property ($past(i_multidrop_mode && i_async_mode) |-> !o_parity_active)
    else $error("parity active in multidrop format");
  AST_BUS_ACK: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
                                |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
    else $error("bus answer timing");
  // Main scenarios reached
  cover property (drop);
  cover property (i_rx_char_done && i_rx_mp_bit && eff);
  cover property (o_tx_end_irq);
endmodule
`default_nettype wire

/* test/scm_remote_station.sv */
// Remote station model: clocks the line inside frames, resolves the pin
`timescale 1ns/1ps
`default_nettype none
module scm_remote_station (
  input  wire logic i_run,       // Frame active: remote drives its clock
  input  wire logic i_dev_sck,   // Level from the device
  input  wire logic i_dev_oe_n,  // Low while the device drives
  output logic      o_pin        // Resolved pin level
);
  logic clk_q = 1'b1;  // Remote clock, parked high between frames
  // 64 ns clock, phase unrelated to the system clock, still outside frames
  initial begin
    #7;
    forever begin
      #32;
      clk_q = i_run ? !clk_q : 1'b1;
    end
  end
  // Pull-up holds the line high when nobody drives it
  always_comb o_pin = !i_dev_oe_n ? i_dev_sck : (i_run ? clk_q : 1'b1);
endmodule
`default_nettype wire

/* test/scm_serial_ctrl_tb.sv */
// Testbench for the serial control block
`timescale 1ns/1ps
`default_nettype none
module scm_serial_ctrl_tb;
  // ----
  // Signals
  // ----
  logic        clk = 0, rst = 1, en = 1, rd = 0, wr = 0;
  logic [3:0]  addr = 4'h0, be = 4'hF;
  logic [31:0] wdata = 32'h0, rdata, q;
  logic        am = 1, mdm = 0, pen = 0, podd = 0, rxd = 0, mp = 0, fe = 0, full = 0;
  logic        txf = 0, baud = 0, run = 0, bon = 0, sck_prev = 1, wreq, dlv, fset;
  logic        feset, ovset, pact, pod, txirq, ctick, ext, sck_o, oe_n, irq, pin;
  logic [1:0]  bcnt = 2'h0;
  int          num_errors = 0, n_compared = 0, ticks = 0, tog = 0;
  scm_serial_ctrl dut (
    .i_sys_clk(clk), .i_sys_rst(rst), .i_clk_en(en), .i_avs_address(addr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(be),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_async_mode(am),
    .i_multidrop_mode(mdm), .i_parity_en(pen), .i_parity_odd(podd),
    .i_rx_char_done(rxd), .i_rx_mp_bit(mp), .i_rx_frame_err(fe), .i_rx_full_flag(full),
    .o_rx_deliver(dlv), .o_rx_full_set(fset), .o_frame_err_set(feset),
    .o_overrun_set(ovset), .o_parity_active(pact), .o_parity_odd(pod),
    .i_tx_end_flag(txf), .o_tx_end_irq(txirq), .i_baud_tick(baud), .o_clk_tick(ctick),
    .o_ext_clk(ext), .i_sck(pin), .o_sck(sck_o), .o_sck_oe_n(oe_n), .o_irq(irq));
  scm_remote_station u_far (.i_run(run), .i_dev_sck(sck_o), .i_dev_oe_n(oe_n), .o_pin(pin));
  initial begin
    forever #2.5 clk = ~clk;
  end
  // Baud tick every fourth cycle; tick and pin toggle counters
  always @(posedge clk) begin
    bcnt <= bcnt + 2'h1;
    baud <= bon && bcnt == 2'h3;
    sck_prev <= sck_o;
    if (ctick === 1'b1) ticks++;
    if (sck_o !== sck_prev) tog++;
  end
  // ----
  // Shared tasks
  // ----
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  // Avalon access: hold until waitrequest is seen low, bounded wait
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= {24'h0, d};
    @(posedge clk);
    while (wreq !== 1'b0 && n < 40) begin
      @(posedge clk);
      n++;
    end
    chk(n < 40, 1, "bus hang");
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic rx(input logic m, input logic f, input logic u);
    @(posedge clk);
    rxd <= 1'b1;
    mp <= m;
    fe <= f;
    full <= u;
    @(posedge clk);
    rxd <= 1'b0;
    #1;
  endtask
  task automatic clk_case(input logic a, input logic [1:0] s, input logic lk, input logic bd,
                          input logic eo, input int lo, input int hi, input int tlo, input int thi);
    @(posedge clk);
    am <= a;
    bus(1'b1, scm_pkg::ADDR_CONTROL, {6'h0, s});
    run <= lk;
    bon <= bd;
    wt(16);
    ticks = 0;
    tog = 0;
    wt(128);
    chk(oe_n, eo, "pin drive");
    chk(ext, s[1], "clock source");
    chk(ticks >= lo && ticks <= hi, 1, "tick count");
    chk(tog >= tlo && tog <= thi, 1, "pin toggles");
    @(posedge clk);
    run <= 1'b0;
    bon <= 1'b0;
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_regs;
    bus(1'b0, scm_pkg::ADDR_CONTROL, 8'h00);
    chk(q, 32'h0, "control reset");
    bus(1'b1, 4'h2, 8'hFF);
    bus(1'b0, 4'h2, 8'h00);
    chk(q, 32'h0, "unmapped read");
    bus(1'b1, scm_pkg::ADDR_CONTROL, 8'hF4);
    bus(1'b0, scm_pkg::ADDR_CONTROL, 8'h00);
    chk(q, 32'h4, "control bits");
  endtask
  task automatic t_filter;
    @(posedge clk);
    mdm <= 1'b1;
    bus(1'b1, scm_pkg::ADDR_IRQ_MASK, 8'h03);
    bus(1'b1, scm_pkg::ADDR_CONTROL, 8'h08);
    rx(1'b0, 1'b1, 1'b0);
    chk(dlv, 0, "discarded char delivered");
    chk({fset, feset, ovset}, 0, "flags on discarded char");
    wt(2);
    chk(irq, 1, "discard event irq");
    rx(1'b1, 1'b0, 1'b0);
    chk({dlv, fset}, 3, "address char");
    bus(1'b0, scm_pkg::ADDR_CONTROL, 8'h00);
    chk(q, 32'h0, "filter bit stays set");
    bus(1'b1, scm_pkg::ADDR_IRQ_STAT, 8'h03);
    bus(1'b1, scm_pkg::ADDR_CONTROL, 8'h08);
    @(posedge clk);
    mdm <= 1'b0;
    rx(1'b0, 1'b1, 1'b0);
    chk(feset, 1, "frame error lost without multidrop");
    rx(1'b0, 1'b0, 1'b0);
    chk(dlv, 1, "char dropped without multidrop");
    @(posedge clk);
    am <= 1'b0;
    mdm <= 1'b1;
    rx(1'b0, 1'b0, 1'b1);
    chk({dlv, ovset}, 1, "sync mode overrun");
    chk(irq, 0, "irq after clear");
    @(posedge clk);
    am <= 1'b1;
    mdm <= 1'b0;
  endtask
  task automatic t_txend;
    bus(1'b1, scm_pkg::ADDR_IRQ_MASK, 8'h04);
    bus(1'b1, scm_pkg::ADDR_CONTROL, 8'h00);
    @(posedge clk);
    txf <= 1'b1;
    wt(3);
    chk(txirq, 0, "tx end not masked");
    chk(irq, 1, "tx end event irq");
    bus(1'b1, scm_pkg::ADDR_CONTROL, 8'h04);
    wt(2);
    chk(txirq, 1, "tx end request missing");
    @(posedge clk);
    txf <= 1'b0;
    wt(2);
    chk(txirq, 0, "tx end request stuck");
    bus(1'b1, scm_pkg::ADDR_IRQ_STAT, 8'h04);
    wt(2);
    chk(irq, 0, "irq not cleared");
  endtask
  task automatic t_parity;
    @(posedge clk);
    am <= 1'b1;
    pen <= 1'b1;
    podd <= 1'b1;
    mdm <= 1'b1;
    wt(3);
    chk(pact, 0, "parity in multidrop");
    @(posedge clk);
    mdm <= 1'b0;
    wt(3);
    chk({pact, pod}, 3, "parity lost");
  endtask
  task automatic print_verdict;
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Watchdog
  initial begin
    #100000;
    num_errors++;
    print_verdict();
  end
  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_filter();
    t_txend();
    clk_case(1'b1, 2'h0, 1'b1, 1'b1, 1'b1, 31, 33, 0, 999);
    clk_case(1'b1, 2'h1, 1'b0, 1'b1, 1'b0, 31, 33, 3, 5);
    clk_case(1'b1, 2'h2, 1'b1, 1'b1, 1'b1, 9, 11, 0, 999);
    clk_case(1'b1, 2'h3, 1'b1, 1'b0, 1'b1, 9, 11, 0, 999);
    clk_case(1'b0, 2'h0, 1'b0, 1'b1, 1'b0, 15, 17, 31, 33);
    clk_case(1'b0, 2'h1, 1'b0, 1'b1, 1'b0, 15, 17, 31, 33);
    clk_case(1'b0, 2'h2, 1'b1, 1'b1, 1'b1, 9, 11, 0, 999);
    clk_case(1'b0, 2'h3, 1'b1, 1'b0, 1'b1, 9, 11, 0, 999);
    t_parity();
    print_verdict();
  end
endmodule
bind scm_serial_ctrl scm_serial_ctrl_monitor u_mon (
  .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_avs_address(i_avs_address),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
  .i_avs_byteenable(i_avs_byteenable), .o_avs_waitrequest(o_avs_waitrequest),
  .i_async_mode(i_async_mode), .i_multidrop_mode(i_multidrop_mode),
  .i_rx_char_done(i_rx_char_done), .i_rx_mp_bit(i_rx_mp_bit), .i_rx_frame_err(i_rx_frame_err),
  .i_rx_full_flag(i_rx_full_flag), .o_rx_deliver(o_rx_deliver), .o_rx_full_set(o_rx_full_set),
  .o_frame_err_set(o_frame_err_set), .o_overrun_set(o_overrun_set),
  .o_parity_active(o_parity_active), .i_tx_end_flag(i_tx_end_flag),
  .o_tx_end_irq(o_tx_end_irq), .o_ext_clk(o_ext_clk), .o_sck_oe_n(o_sck_oe_n));
`default_nettype wire
